// [design/duc_top.sv]
// top: ahb-lite register file and update control of a two-channel 12-bit d/a converter
// Behaviour
// - align 0: code from bits 11..0
// - align 1: code from bits 15..4
// - sync off: outputs update independently
// - sync on: updates follow the adc
// - adc enable signal gates updates only while sync is on
// - event input starts channel 0
// - module stop halts the converter logic
//
// The AHB-Lite slave port and the address map were decided locally.
module duc_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // partner and event inputs
  input wire logic adc_upd_en,
  input wire logic evt_start,
  // converter side
  output logic [11:0] code0,
  output logic [11:0] code1,
  output logic [1:0] out_on
);
  logic [15:0] data0;
  logic [15:0] data1;
  logic [7:0] enable_reg;
  logic [7:0] sync_reg;
  logic [7:0] format_reg;
  logic [7:0] stop_reg;
  logic [1:0] pend;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic run;
  logic [1:0] ch_en;
  logic wr_d0;
  logic wr_d1;
  logic evt_go;
  logic bus_wr;
  logic rd_go;
  logic [6:0] wr_sel;
  logic [31:0] next_hrdata;
  logic [1:0] st_code;
  logic [11:0] st_code0;
  logic [11:0] st_code1;
  duc_upd_if upd ();

  // one-hot register select, shared by the write strobes and the read mux
  function automatic logic [6:0] reg_sel(input logic [7:0] a);
    reg_sel[0] = (a == duc_pkg::OFF_DATA0);
    reg_sel[1] = (a == duc_pkg::OFF_DATA1);
    reg_sel[2] = (a == duc_pkg::OFF_ENABLE);
    reg_sel[3] = (a == duc_pkg::OFF_SYNC);
    reg_sel[4] = (a == duc_pkg::OFF_FORMAT);
    reg_sel[5] = (a == duc_pkg::OFF_STOP);
    reg_sel[6] = (a == duc_pkg::OFF_STATUS);
  endfunction : reg_sel

  // module stop freezes everything but the register file
  assign run = !stop_reg[duc_pkg::STOP_BIT];
  assign ch_en = enable_reg[duc_pkg::EN_ALL_BIT] ?
                 {enable_reg[duc_pkg::EN_CH1_BIT], enable_reg[duc_pkg::EN_CH0_BIT]} : 2'h0;

  // bus: capture address phase, write in data phase, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (hready) begin
      wr_pend <= bus_wr;
      wr_addr <= haddr;
    end
  end

  // qualified requests; non-word writes are dropped here
  assign bus_wr = hsel && hwrite && (htrans == duc_pkg::HTRANS_NONSEQ) && (hsize == duc_pkg::HSIZE_WORD);
  assign rd_go = hready && hsel && !hwrite && (htrans == duc_pkg::HTRANS_NONSEQ);

  // status has no write strobe, so writes to it fall away
  assign wr_sel = wr_pend ? reg_sel(wr_addr) : 7'h00;
  assign wr_d0 = wr_sel[0];
  assign wr_d1 = wr_sel[1];
  assign evt_go = evt_start && stop_reg[duc_pkg::EVT_EN_BIT] == 1'b1 && run;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data0 <= duc_pkg::RST_DATA;
    end else if (wr_d0) begin
      data0 <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data1 <= duc_pkg::RST_DATA;
    end else if (wr_d1) begin
      data1 <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_reg <= duc_pkg::RST_ENABLE;
    end else if (wr_sel[2]) begin
      enable_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_reg <= duc_pkg::RST_SYNC;
    end else if (wr_sel[3]) begin
      sync_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      format_reg <= duc_pkg::RST_FORMAT;
    end else if (wr_sel[4]) begin
      format_reg <= hwdata[7:0];
    end
  end

  // leaves reset in module stop, so software must start the block itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_reg <= duc_pkg::RST_STOP;
    end else if (wr_sel[5]) begin
      stop_reg <= hwdata[7:0];
    end
  end

  // pending flags: a new write wins over the take in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= 2'h0;
    end else begin
      pend[0] <= wr_d0 || evt_go || (pend[0] && !upd.take[0]);
      pend[1] <= wr_d1 || (pend[1] && !upd.take[1]);
    end
  end

  assign upd.pend = pend;
  assign upd.code0 = duc_pkg::align_code(data0, format_reg[duc_pkg::ALIGN_BIT]);
  assign upd.code1 = duc_pkg::align_code(data1, format_reg[duc_pkg::ALIGN_BIT]);

  duc_out_stage u_stage (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(run),
    .sync_on(sync_reg[duc_pkg::SYNC_BIT]),
    .adc_upd_en(adc_upd_en),
    .ch_en(ch_en),
    .upd(upd),
    .code0(st_code0),
    .code1(st_code1),
    .out_on(st_code)
  );

  assign code0 = st_code0;
  assign code1 = st_code1;
  assign out_on = st_code;

  // read mux; unmapped offsets read zero
  always_comb begin
    logic [6:0] rd_sel;
    rd_sel = reg_sel(haddr);
    next_hrdata = 32'h0000_0000;
    if (rd_sel[0]) begin
      next_hrdata = {16'h0000, data0};
    end
    if (rd_sel[1]) begin
      next_hrdata = {16'h0000, data1};
    end
    if (rd_sel[2]) begin
      next_hrdata = {24'h000000, enable_reg};
    end
    if (rd_sel[3]) begin
      next_hrdata = {24'h000000, sync_reg};
    end
    if (rd_sel[4]) begin
      next_hrdata = {24'h000000, format_reg};
    end
    if (rd_sel[5]) begin
      next_hrdata = {24'h000000, stop_reg};
    end
    if (rd_sel[6]) begin
      next_hrdata = {26'h0000000, out_on, pend, run, sync_reg[duc_pkg::SYNC_BIT]};
    end
  end

  // read data registered in the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_go) begin
      hrdata <= next_hrdata;
    end
  end

  // no wait states: every register answers in one data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end
endmodule : duc_top

// [inc/duc_pkg.sv]
// package: register map, field layout and reset values of the d/a update control block
package duc_pkg;
  localparam int unsigned DATA_W = 12;
  localparam int unsigned REG_W = 16;
  // register byte offsets
  localparam logic [7:0] OFF_DATA0 = 8'h00;
  localparam logic [7:0] OFF_DATA1 = 8'h04;
  localparam logic [7:0] OFF_ENABLE = 8'h08;
  localparam logic [7:0] OFF_SYNC = 8'h0c;
  localparam logic [7:0] OFF_FORMAT = 8'h10;
  localparam logic [7:0] OFF_STOP = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  // field positions
  localparam int unsigned EN_CH0_BIT = 6;
  localparam int unsigned EN_CH1_BIT = 7;
  localparam int unsigned EN_ALL_BIT = 5;
  localparam int unsigned SYNC_BIT = 7;
  localparam int unsigned ALIGN_BIT = 7;
  localparam int unsigned STOP_BIT = 0;
  localparam int unsigned EVT_EN_BIT = 1;
  // reset values and ahb-lite encodings
  localparam logic [15:0] RST_DATA = 16'h0000;
  localparam logic [7:0] RST_ENABLE = 8'h1f;
  localparam logic [7:0] RST_SYNC = 8'h00;
  localparam logic [7:0] RST_FORMAT = 8'h00;
  localparam logic [7:0] RST_STOP = 8'h01;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // pull the 12-bit code out of a 16-bit data register
  function automatic logic [DATA_W-1:0] align_code(input logic [REG_W-1:0] r, input logic left);
    align_code = left ? r[15:4] : r[11:0];
  endfunction : align_code
endpackage : duc_pkg

// [inc/duc_upd_if.sv]
// interface: channel update request and result between register file and output stage
interface duc_upd_if;
  logic [1:0] pend;
  logic [1:0] take;
  logic [11:0] code0;
  logic [11:0] code1;
  modport regs (output pend, output code0, output code1, input take);
  modport stage (input pend, input code0, input code1, output take);
endinterface : duc_upd_if

// [design/duc_out_stage.sv]
// output stage: applies pending codes to the converter, gated by sync window and enable
module duc_out_stage (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic run,
  input wire logic sync_on,
  input wire logic adc_upd_en,
  input wire logic [1:0] ch_en,
  // request channel
  duc_upd_if.stage upd,
  // converter side
  output logic [11:0] code0,
  output logic [11:0] code1,
  output logic [1:0] out_on
);
  logic allow;
  // sync off: update freely; sync on: only when the adc permits
  assign allow = run && (!sync_on || adc_upd_en);

  always_comb begin
    upd.take = allow ? (upd.pend & ch_en) : 2'h0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code0 <= 12'h000;
      code1 <= 12'h000;
    end else begin
      if (upd.take[0]) begin
        code0 <= upd.code0;
      end
      if (upd.take[1]) begin
        code1 <= upd.code1;
      end
    end
  end

  // output drivers stay off while stopped or disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_on <= 2'h0;
    end else begin
      out_on <= run ? ch_en : 2'h0;
    end
  end
endmodule : duc_out_stage

// [dv/duc_monitor.sv]
// checker: bus answer and update timing seen at the top ports
module duc_monitor (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // converter
  input wire logic adc_upd_en,
  input wire logic [11:0] code0,
  input wire logic [11:0] code1,
  input wire logic [1:0] out_on
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sync_wr;
  logic sync;
  logic stop_wr;
  logic stopped;
  wire logic acc = hsel && hready && htrans == duc_pkg::HTRANS_NONSEQ;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // shadow of the sync bit so the update checks know the mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sync_wr <= 1'b0;
    else sync_wr <= acc && hwrite && haddr == duc_pkg::OFF_SYNC;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sync <= 1'b0;
    else if (sync_wr) sync <= hwdata[duc_pkg::SYNC_BIT];
  end
  // shadow of the stop bit, reset into module stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) stop_wr <= 1'b0;
    else stop_wr <= acc && hwrite && haddr == duc_pkg::OFF_STOP;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) stopped <= 1'b1;
    else if (stop_wr) stopped <= hwdata[duc_pkg::STOP_BIT];
  end
  sequence s_rd; acc && !hwrite; endsequence
  property p_rdy; hreadyout; endproperty
  a_rdy: assert property (p_rdy) else $error("hreadyout low");
  property p_resp; !hresp; endproperty
  a_resp: assert property (p_resp) else $error("hresp not okay");
  property p_unm; s_rd ##0 (haddr > 8'h18) |=> hrdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_stat; s_rd ##0 (haddr == duc_pkg::OFF_STATUS) |=> hrdata[0] == $past(sync); endproperty
  a_stat: assert property (p_stat) else $error("status sync bit wrong");
  property p_en0; $changed(code0) |-> out_on[0]; endproperty
  a_en0: assert property (p_en0) else $error("code0 moved while off");
  property p_en1; $changed(code1) |-> out_on[1]; endproperty
  a_en1: assert property (p_en1) else $error("code1 moved while off");
  property p_upd; $past(sync) && $changed(code0) |-> $past(adc_upd_en); endproperty
  a_upd: assert property (p_upd) else $error("update outside adc window");
  property p_upd1; $past(sync) && $changed(code1) |-> $past(adc_upd_en); endproperty
  a_upd1: assert property (p_upd1) else $error("code1 update outside adc window");
  property p_held; sync && !adc_upd_en |=> $stable(code0) && $stable(code1); endproperty
  a_held: assert property (p_held) else $error("update while window shut");
  property p_stop; stopped |=> out_on == 2'h0 && $stable(code0) && $stable(code1); endproperty
  a_stop: assert property (p_stop) else $error("outputs active in module stop");
endmodule : duc_monitor

bind duc_top duc_monitor mon (.*);

// [dv/duc_adc_model.sv]
// partner: adc update-enable source, open one cycle in every four or held shut
module duc_adc_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hold,
  output logic adc_upd_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt <= 2'h0;
    else cnt <= cnt + 2'h1;
  end
  // hold stands for a long adc scan that keeps the window shut
  assign adc_upd_en = !hold && cnt == 2'h3;
endmodule : duc_adc_model

// [dv/dac_update_control_test.sv]
// testbench: register sequences over ahb-lite with expected codes
module dac_update_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, evt_start, hold, hreadyout, hresp, adc_upd_en;
  logic [7:0] haddr;
  logic [1:0] htrans, out_on;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, q;
  logic [11:0] code0, code1;
  int failures = 0;
  int checked = 0;
  duc_top uut (.hready(hreadyout), .*);
  duc_adc_model adc (.*);
  initial begin
    forever #2.5 hclk = ~hclk;
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= a;
    htrans <= duc_pkg::HTRANS_NONSEQ;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : bus
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask : rdc
  task automatic report_and_stop();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    #10us;
    failures++;
    report_and_stop();
  end
  initial begin
    {hsel, hwrite, evt_start, hold} = 4'h0;
    {haddr, htrans, hwdata} = 42'h0;
    hsize = duc_pkg::HSIZE_WORD;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("enable", duc_pkg::OFF_ENABLE, 32'h1f);
    rdc("stop", duc_pkg::OFF_STOP, 32'h01);
    rdc("sync", duc_pkg::OFF_SYNC, 32'h0);
    rdc("format", duc_pkg::OFF_FORMAT, 32'h0);
    rdc("unmapped", 8'h1c, 32'h0);
    bus(1'b1, duc_pkg::OFF_STOP, 32'h2);
    bus(1'b1, duc_pkg::OFF_ENABLE, 32'he0);
    bus(1'b1, duc_pkg::OFF_DATA0, 32'habcd);
    repeat (4) @(posedge hclk);
    chk("code0", 32'hbcd, 32'(code0));
    chk("out_on", 32'h3, 32'(out_on));
    bus(1'b1, duc_pkg::OFF_FORMAT, 32'h80);
    bus(1'b1, duc_pkg::OFF_DATA1, 32'h1234);
    repeat (4) @(posedge hclk);
    chk("code1", 32'h123, 32'(code1));
    bus(1'b1, duc_pkg::OFF_SYNC, 32'h80);
    hold <= 1'b1;
    bus(1'b1, duc_pkg::OFF_DATA0, 32'h0567);
    bus(1'b1, duc_pkg::OFF_DATA1, 32'h4560);
    repeat (8) @(posedge hclk);
    chk("code0", 32'hbcd, 32'(code0));
    rdc("status", duc_pkg::OFF_STATUS, 32'h3f);
    hold <= 1'b0;
    repeat (8) @(posedge hclk);
    chk("code0", 32'h056, 32'(code0));
    chk("code1", 32'h456, 32'(code1));
    bus(1'b1, duc_pkg::OFF_SYNC, 32'h0);
    bus(1'b1, duc_pkg::OFF_FORMAT, 32'h0);
    repeat (4) @(posedge hclk);
    chk("code0", 32'h056, 32'(code0));
    evt_start <= 1'b1;
    @(posedge hclk);
    evt_start <= 1'b0;
    repeat (4) @(posedge hclk);
    chk("code0", 32'h567, 32'(code0));
    bus(1'b1, duc_pkg::OFF_STOP, 32'h3);
    bus(1'b1, duc_pkg::OFF_DATA1, 32'h0fff);
    repeat (4) @(posedge hclk);
    chk("code1", 32'h456, 32'(code1));
    bus(1'b1, duc_pkg::OFF_STOP, 32'h2);
    repeat (4) @(posedge hclk);
    chk("code1", 32'hfff, 32'(code1));
    bus(1'b1, duc_pkg::OFF_ENABLE, 32'h60);
    bus(1'b1, duc_pkg::OFF_DATA1, 32'h0aaa);
    repeat (4) @(posedge hclk);
    chk("out_on", 32'h1, 32'(out_on));
    chk("code1", 32'hfff, 32'(code1));
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("stop", duc_pkg::OFF_STOP, 32'h01);
    chk("out_on", 32'h0, 32'(out_on));
    report_and_stop();
  end
endmodule : dac_update_control_test
